// [hw/sahp_defs.svh]
// constants for the sampling converter host port
`ifndef SAHP_DEFS_SVH
`define SAHP_DEFS_SVH

`define SAHP_RES_W 14
`define SAHP_CODE_W 4
`define SAHP_NUM_CH 4
`define SAHP_CLK_PERIOD_NS 5
`define SAHP_CHAN_TIME_NS 3000
`define SAHP_CHAN_CYCLES ((`SAHP_CHAN_TIME_NS) / (`SAHP_CLK_PERIOD_NS))
`define SAHP_TICK_W 10
`define SAHP_TICK_ZERO 10'h000
`define SAHP_TICK_LAST (10'(`SAHP_CHAN_CYCLES - 1))
`define SAHP_SEQ_W 12
`define SAHP_SEQ_ZERO 12'h000
`define SAHP_MODE_RESET 4'h0
`define SAHP_CH_FIRST 2'h0
`define SAHP_CH_LAST 2'h3
`define SAHP_CH_STEP 2'h1
`define SAHP_RES_ZERO 14'h0000

`endif

// [hw/sahp_pkg.sv]
// types shared by the sampling converter host port
package sahp_pkg;

  // mode code as written on the shared lines, bit 3 down to bit 0
  typedef struct packed {
    logic power_down;
    logic bank_b;
    logic [1:0] chan_last;
  } sahp_mode_s;

  typedef enum logic [0:0] {
    SAHP_IDLE = 1'b0,
    SAHP_CONV = 1'b1
  } sahp_state_e;

  typedef logic [1:0] sahp_chan_t;

endpackage : sahp_pkg

// [hw/sahp_host_port.sv]
// sequencer, result memory and parallel host port of the sampling converter
`include "sahp_defs.svh"

module sahp_host_port
  import sahp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sample_start,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic [`SAHP_RES_W-1:0] data_in,
  input wire logic [`SAHP_RES_W-1:0] conv_data,
  output logic [`SAHP_RES_W-1:0] data_out_q,
  output logic data_oe_q,
  output logic done_n_q,
  output logic hold_q,
  output logic bank_b_q,
  output logic [1:0] conv_chan_q,
  output logic power_down_q
);

  function automatic sahp_chan_t sahp_next(input sahp_chan_t cur, input sahp_chan_t last);
    sahp_chan_t nxt;
    nxt = (cur == last) ? `SAHP_CH_FIRST : 2'(cur + `SAHP_CH_STEP);
    return nxt;
  endfunction : sahp_next

  ////////////////////////////////////////////////////////////////////////////
  // strobe edges

  logic start_q;
  logic wr_act_q;
  logic rd_act_q;
  logic wr_act;
  logic rd_act;
  logic start_edge;
  logic wr_done;
  logic rd_fall;
  logic rd_rise;
  logic start_ok;
  logic chan_end;
  logic seq_end;

  sahp_state_e state_q;
  sahp_mode_s mode_q;
  logic [`SAHP_CODE_W-1:0] code_q;
  sahp_chan_t seq_last_q;
  sahp_chan_t rd_ptr_q;
  logic [`SAHP_TICK_W-1:0] tick_q;
  logic [`SAHP_SEQ_W-1:0] seq_cyc_q;
  logic [`SAHP_RES_W-1:0] mem_q [`SAHP_NUM_CH];

  // select high gates both strobes, so either rising ends an access
  assign wr_act = !chip_select_n && !write_n;
  assign rd_act = !chip_select_n && !read_n;
  assign start_edge = sample_start && !start_q;
  assign wr_done = wr_act_q && !wr_act;
  assign rd_fall = rd_act && !rd_act_q;
  assign rd_rise = rd_act_q && !rd_act;
  assign start_ok = start_edge && (state_q == SAHP_IDLE) && !mode_q.power_down;
  assign chan_end = (state_q == SAHP_CONV) && (tick_q == `SAHP_TICK_LAST);
  assign seq_end = chan_end && (conv_chan_q == seq_last_q);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      start_q <= 1'b0;
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end
    else
    begin
      start_q <= sample_start;
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode programming

  // code is held from the last active cycle, so data may change as the strobe rises
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      code_q <= `SAHP_MODE_RESET;
    else if (wr_act)
      code_q <= data_in[`SAHP_CODE_W-1:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= sahp_mode_s'(`SAHP_MODE_RESET);
      power_down_q <= 1'b0;
    end
    else if (wr_done)
    begin
      mode_q <= sahp_mode_s'(code_q);
      power_down_q <= code_q[`SAHP_CODE_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_q <= SAHP_IDLE;
    else
    begin
      case (state_q)
        SAHP_IDLE:
        begin
          if (start_ok)
            state_q <= SAHP_CONV;
        end
        SAHP_CONV:
        begin
          if (seq_end)
            state_q <= SAHP_IDLE;
        end
        default:
          state_q <= SAHP_IDLE;
      endcase
    end
  end

  // bank and count are frozen per sequence; a rewrite mid-sequence waits
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      seq_last_q <= `SAHP_CH_FIRST;
      bank_b_q <= 1'b0;
    end
    else if (start_ok)
    begin
      seq_last_q <= mode_q.chan_last;
      bank_b_q <= mode_q.bank_b;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      tick_q <= `SAHP_TICK_ZERO;
    else if (start_ok || chan_end)
      tick_q <= `SAHP_TICK_ZERO;
    else if (state_q == SAHP_CONV)
      tick_q <= 10'(tick_q + 10'h001);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      conv_chan_q <= `SAHP_CH_FIRST;
    else if (start_ok)
      conv_chan_q <= `SAHP_CH_FIRST;
    else if (chan_end)
      conv_chan_q <= sahp_next(conv_chan_q, seq_last_q);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      hold_q <= 1'b0;
    else if (start_ok)
      hold_q <= 1'b1;
    else if (seq_end)
      hold_q <= 1'b0;
  end

  // converter output is settled on the last cycle of each channel slot
  always_ff @(posedge clk)
  begin
    if (chan_end)
      mem_q[conv_chan_q] <= conv_data;
  end

  // hardware end of sequence wins over a read in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      done_n_q <= 1'b1;
    else if (seq_end)
      done_n_q <= 1'b0;
    else if (rd_fall)
      done_n_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rd_ptr_q <= `SAHP_CH_FIRST;
    else if (start_ok)
      rd_ptr_q <= `SAHP_CH_FIRST;
    else if (rd_rise)
      rd_ptr_q <= sahp_next(rd_ptr_q, seq_last_q);
  end

  // reads during a sequence return the stored results, new ones for channels already converted; no interlock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      data_out_q <= `SAHP_RES_ZERO;
      data_oe_q <= 1'b0;
    end
    else
    begin
      data_oe_q <= rd_act;
      if (rd_act)
        data_out_q <= mem_q[rd_ptr_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      seq_cyc_q <= `SAHP_SEQ_ZERO;
    else if (start_ok)
      seq_cyc_q <= `SAHP_SEQ_ZERO;
    else if (state_q == SAHP_CONV)
      seq_cyc_q <= 12'(seq_cyc_q + 12'h001);
  end

  a_start_freeze: assert property (@(posedge clk) disable iff (reset)
    start_ok |=> hold_q && (state_q == SAHP_CONV) && (conv_chan_q == `SAHP_CH_FIRST))
    else $error("start edge did not freeze holds");

  a_done_falls: assert property (@(posedge clk) disable iff (reset)
    seq_end |=> !done_n_q && !hold_q ##1 !done_n_q || $past(rd_fall))
    else $error("completion output did not fall at sequence end");

  a_read_data: assert property (@(posedge clk) disable iff (reset)
    rd_act |=> data_oe_q && (data_out_q == $past(mem_q[rd_ptr_q])))
    else $error("read data does not match addressed result");

  a_bus_release: assert property (@(posedge clk) disable iff (reset)
    (chip_select_n && $past(chip_select_n)) |-> !data_oe_q)
    else $error("bus driven while deselected");

  a_mode_capture: assert property (@(posedge clk) disable iff (reset)
    wr_act ##1 !wr_act |=> (mode_q == sahp_mode_s'($past(data_in[`SAHP_CODE_W-1:0], 2))))
    else $error("mode code not captured on strobe release");

  a_ptr_wrap: assert property (@(posedge clk) disable iff (reset)
    (rd_rise && !start_ok && (rd_ptr_q == seq_last_q)) |=> (rd_ptr_q == `SAHP_CH_FIRST))
    else $error("read pointer did not wrap to first channel");

  a_done_rises: assert property (@(posedge clk) disable iff (reset)
    (!done_n_q && rd_fall && !seq_end) |=> done_n_q)
    else $error("completion output not returned high on read");

  a_seq_length: assert property (@(posedge clk) disable iff (reset)
    seq_end |-> (seq_cyc_q ==
      12'(({10'h000, seq_last_q} + 12'h001) * 12'(`SAHP_CHAN_CYCLES) - 12'h001)))
    else $error("sequence length wrong");

  a_start_ignored: assert property (@(posedge clk) disable iff (reset)
    ((state_q == SAHP_CONV) && !chan_end && start_edge) |=>
      (state_q == SAHP_CONV) && $stable(seq_last_q) && (tick_q != `SAHP_TICK_ZERO))
    else $error("start accepted during a sequence");

  c_four_chan: cover property (@(posedge clk) disable iff (reset)
    seq_end && (seq_last_q == `SAHP_CH_LAST));

  c_ptr_wrap: cover property (@(posedge clk) disable iff (reset)
    rd_rise && (rd_ptr_q == seq_last_q) && (seq_last_q != `SAHP_CH_FIRST));

  c_start_busy: cover property (@(posedge clk) disable iff (reset)
    (state_q == SAHP_CONV) && start_edge);

  c_power_down: cover property (@(posedge clk) disable iff (reset)
    start_edge && mode_q.power_down);

endmodule : sahp_host_port

// [test/sahp_host_model.sv]
// host side of the parallel port: mode writes, start pulses, result reads
module sahp_host_model
  import sahp_pkg::*;
(
  input wire logic clk,
  input wire logic [13:0] data_out_q,
  input wire logic data_oe_q,
  output logic [13:0] data_in,
  output logic chip_select_n,
  output logic write_n,
  output logic read_n,
  output logic sample_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  logic [3:0] val;
  logic [13:0] last_q = 14'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // released lines show the inverse of the last level, never a stale copy
  always @(posedge clk) last_q <= data_in;
  assign data_in = data_oe_q ? data_out_q : {~last_q[13:4], drv ? val : ~last_q[3:0]};
  initial
  begin
    chip_select_n = 1'b1;
    write_n = 1'b1;
    read_n = 1'b1;
    sample_start = 1'b0;
    drv = 1'b0;
    val = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic write_mode(input logic [3:0] code, input bit cs_first);
    @(negedge clk);
    chip_select_n = 1'b0;
    write_n = 1'b0;
    drv = 1'b1;
    val = code;
    @(negedge clk);
    if (cs_first) chip_select_n = 1'b1;
    else write_n = 1'b1;
    @(negedge clk);
    chip_select_n = 1'b1;
    write_n = 1'b1;
    drv = 1'b0;
  endtask : write_mode
  // held high six cycles to honour the minimum pulse width
  task automatic pulse_start();
    @(negedge clk);
    sample_start = 1'b1;
    repeat (6) @(negedge clk);
    sample_start = 1'b0;
  endtask : pulse_start
  task automatic read_word(output logic [13:0] word);
    @(negedge clk);
    chip_select_n = 1'b0;
    read_n = 1'b0;
    repeat (6) @(negedge clk);
    word = data_in;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : read_word
endmodule : sahp_host_model

// [test/tb_simultaneous_sampling_adc_host_port.sv]
// self-checking bench for the sampling converter host port
module tb_simultaneous_sampling_adc_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  import sahp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sample_start, chip_select_n, write_n, read_n, data_oe_q, done_n_q;
  logic hold_q, bank_b_q, power_down_q;
  logic [13:0] data_in, conv_data, data_out_q;
  logic [1:0] conv_chan_q;
  int fail_count = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  // result pattern marks bank and channel, asymmetric to expose bit order
  assign conv_data = {bank_b_q, conv_chan_q, 3'h5, conv_chan_q, 6'h2C};
  sahp_host_port u_dut (.clk(clk), .reset(reset), .sample_start(sample_start),
    .chip_select_n(chip_select_n), .write_n(write_n), .read_n(read_n), .data_in(data_in),
    .conv_data(conv_data), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .done_n_q(done_n_q), .hold_q(hold_q), .bank_b_q(bank_b_q), .conv_chan_q(conv_chan_q),
    .power_down_q(power_down_q));
  sahp_host_model u_host (.clk(clk), .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .data_in(data_in), .chip_select_n(chip_select_n), .write_n(write_n), .read_n(read_n),
    .sample_start(sample_start));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally(bit bad, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (bad)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : tally
  task automatic chk_flag(logic got, logic exp);
    tally(got !== exp, 32'(got), 32'(exp));
  endtask : chk_flag
  task automatic chk_word(logic [13:0] got, logic [13:0] exp);
    tally(got !== exp, 32'(got), 32'(exp));
  endtask : chk_word
  task automatic chk_count(int got, int exp);
    tally(got != exp, got, exp);
  endtask : chk_count
  task automatic wrap_up();
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  // one sequence: optional mode write, start plus an ignored retrigger, reads
  task automatic run_seq(logic [3:0] code, bit cs_first, bit do_write);
    int k;
    int n;
    logic [13:0] w;
    n = int'(code[1:0]) + 1;
    if (do_write) u_host.write_mode(code, cs_first);
    fork
      u_host.pulse_start();
      begin
        repeat (300) @(negedge clk);
        u_host.pulse_start();
      end
    join_none
    @(negedge clk);
    @(posedge clk);
    repeat (2) @(negedge clk);
    chk_flag(hold_q, 1'b1);
    k = 1;
    while (done_n_q !== 1'b0 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    chk_count(k, 600 * n);
    chk_flag(hold_q, 1'b0);
    for (int i = 0; i <= n; i++)
    begin
      u_host.read_word(w);
      chk_word(w, {code[2], 2'(i % n), 3'h5, 2'(i % n), 6'h2C});
      if (i == 0) chk_flag(done_n_q, 1'b1);
    end
  endtask : run_seq
  task automatic check_reset();
    chk_flag(done_n_q, 1'b1);
    chk_flag(data_oe_q, 1'b0);
    chk_flag(power_down_q, 1'b0);
    run_seq(4'h0, 1'b0, 1'b0);
  endtask : check_reset
  task automatic check_power_down();
    u_host.write_mode(4'h8, 1'b0);
    repeat (2) @(negedge clk);
    chk_flag(power_down_q, 1'b1);
    u_host.pulse_start();
    repeat (20) @(negedge clk);
    chk_flag(hold_q, 1'b0);
    chk_flag(done_n_q, 1'b1);
  endtask : check_power_down
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    check_reset();
    for (int c = 1; c < 8; c++) run_seq(4'(c), c[0], 1'b1);
    check_power_down();
    run_seq(4'h3, 1'b1, 1'b1);
    wrap_up();
  end
  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule : tb_simultaneous_sampling_adc_host_port
